// ==== src/bcu_pkg.sv ====
package bcu_pkg;

    localparam int ADDR_W      = 24;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W        = 3;

    localparam logic [ADDR_W-1:0] PC_RESET   = 24'h000000;
    localparam logic [7:0]        BYTE_RESET = 8'h00;
    localparam logic [SP_W-1:0]   SP_RESET   = 3'h0;
    localparam logic [SP_W-1:0]   SP_STEP    = 3'h1;

    // Branch condition field encodings
    localparam logic [3:0] CC_BRANCH_ALWAYS              = 4'h0;
    localparam logic [3:0] CC_BRANCH_NEVER               = 4'h1;
    localparam logic [3:0] CC_BRANCH_UNSIGNED_HIGHER     = 4'h2;
    localparam logic [3:0] CC_BRANCH_UNSIGNED_LOWER_SAME = 4'h3;
    localparam logic [3:0] CC_BRANCH_UNSIGNED_HIGHER_SAME = 4'h4;
    localparam logic [3:0] CC_BRANCH_CARRY_SET           = 4'h5;
    localparam logic [3:0] CC_BRANCH_NOT_EQUAL           = 4'h6;
    localparam logic [3:0] CC_BRANCH_EQUAL               = 4'h7;
    localparam logic [3:0] CC_BRANCH_OVERFLOW_CLEAR      = 4'h8;
    localparam logic [3:0] CC_BRANCH_OVERFLOW_SET        = 4'h9;
    localparam logic [3:0] CC_BRANCH_PLUS                = 4'ha;
    localparam logic [3:0] CC_BRANCH_MINUS               = 4'hb;
    localparam logic [3:0] CC_BRANCH_SIGNED_GREATER_EQUAL = 4'hc;
    localparam logic [3:0] CC_BRANCH_SIGNED_LESS         = 4'hd;
    localparam logic [3:0] CC_BRANCH_SIGNED_GREATER      = 4'he;
    localparam logic [3:0] CC_BRANCH_SIGNED_LESS_EQUAL   = 4'hf;

    typedef enum logic [3:0] {
        OP_CARRY_OR_BIT,
        OP_CARRY_OR_INVERTED_BIT,
        OP_CARRY_XOR_BIT,
        OP_CARRY_XOR_INVERTED_BIT,
        OP_LOAD_BIT_TO_CARRY,
        OP_LOAD_INVERTED_BIT_TO_CARRY,
        OP_STORE_CARRY_TO_BIT,
        OP_STORE_INVERTED_CARRY_TO_BIT,
        OP_BRANCH,
        OP_UNCONDITIONAL_JUMP,
        OP_RELATIVE_SUBROUTINE_CALL,
        OP_SUBROUTINE_CALL,
        OP_RETURN
    } bcu_op_e;

    // Flag bits of the condition_code_register used here
    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } bcu_flags_s;

    typedef struct packed {
        bcu_op_e           op;
        logic [2:0]        bit_idx;
        logic              mem_sel;
        logic [7:0]        operand;
        logic [ADDR_W-1:0] addr;
        logic [3:0]        cond;
        logic [ADDR_W-1:0] target;
        logic [ADDR_W-1:0] next_pc;
    } bcu_req_s;

    function automatic logic bcu_is_store(bcu_op_e op);
        return (op == OP_STORE_CARRY_TO_BIT) || (op == OP_STORE_INVERTED_CARRY_TO_BIT);
    endfunction

    function automatic logic bcu_is_call(bcu_op_e op);
        return (op == OP_RELATIVE_SUBROUTINE_CALL) || (op == OP_SUBROUTINE_CALL);
    endfunction

endpackage

// ==== src/bcu_bitop.sv ====
`timescale 1ns/100ps
`default_nettype none
module bcu_bitop
    import bcu_pkg::*;
(
    // Operation
    input  wire bcu_pkg::bcu_op_e op,
    input  wire logic [2:0]       bit_idx,
    input  wire logic [7:0]       byte_in,
    input  wire logic             carry_in,
    // Results
    output logic                  carry_out,
    output logic                  carry_we,
    output logic [7:0]            byte_out,
    output logic                  byte_we
);
    logic sel_bit;

    always_comb begin
        sel_bit   = byte_in[bit_idx];
        carry_out = carry_in;
        carry_we  = 1'b1;
        byte_out  = byte_in;
        byte_we   = 1'b0;
        case (op)
            OP_CARRY_OR_BIT:               carry_out = carry_in | sel_bit;
            OP_CARRY_OR_INVERTED_BIT:      carry_out = carry_in | ~sel_bit;
            OP_CARRY_XOR_BIT:              carry_out = carry_in ^ sel_bit;
            OP_CARRY_XOR_INVERTED_BIT:     carry_out = carry_in ^ ~sel_bit;
            OP_LOAD_BIT_TO_CARRY:          carry_out = sel_bit;
            OP_LOAD_INVERTED_BIT_TO_CARRY: carry_out = ~sel_bit;
            OP_STORE_CARRY_TO_BIT: begin
                carry_we          = 1'b0;
                byte_we           = 1'b1;
                byte_out[bit_idx] = carry_in;
            end
            OP_STORE_INVERTED_CARRY_TO_BIT: begin
                carry_we          = 1'b0;
                byte_we           = 1'b1;
                byte_out[bit_idx] = ~carry_in;
            end
            default:                       carry_we = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ==== src/bcu_cond.sv ====
`timescale 1ns/100ps
`default_nettype none
module bcu_cond
    import bcu_pkg::*;
(
    // Flags and condition field
    input  wire bcu_pkg::bcu_flags_s flags,
    input  wire logic [3:0]          cond,
    // Verdict
    output logic                     taken
);
    logic nv;

    always_comb begin
        nv = flags.n ^ flags.v;
        unique case (cond)
            CC_BRANCH_ALWAYS:               taken = 1'b1;
            CC_BRANCH_NEVER:                taken = 1'b0;
            CC_BRANCH_UNSIGNED_HIGHER:      taken = ~(flags.c | flags.z);
            CC_BRANCH_UNSIGNED_LOWER_SAME:  taken = flags.c | flags.z;
            CC_BRANCH_UNSIGNED_HIGHER_SAME: taken = ~flags.c;
            CC_BRANCH_CARRY_SET:            taken = flags.c;
            CC_BRANCH_NOT_EQUAL:            taken = ~flags.z;
            CC_BRANCH_EQUAL:                taken = flags.z;
            CC_BRANCH_OVERFLOW_CLEAR:       taken = ~flags.v;
            CC_BRANCH_OVERFLOW_SET:         taken = flags.v;
            CC_BRANCH_PLUS:                 taken = ~flags.n;
            CC_BRANCH_MINUS:                taken = flags.n;
            CC_BRANCH_SIGNED_GREATER_EQUAL: taken = ~nv;
            CC_BRANCH_SIGNED_LESS:          taken = nv;
            CC_BRANCH_SIGNED_GREATER:       taken = ~(flags.z | nv);
            CC_BRANCH_SIGNED_LESS_EQUAL:    taken = flags.z | nv;
        endcase
    end
endmodule
`default_nettype wire

// ==== src/bcu_core.sv ====
`timescale 1ns/100ps
`default_nettype none
module bcu_core
    import bcu_pkg::*;
(
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    // Request from the decoder
    input  wire logic                     req_valid,
    input  wire bcu_pkg::bcu_req_s        req,
    input  wire bcu_pkg::bcu_flags_s      flags,
    output logic                          req_ready_ff,
    output logic                          done_ff,
    // Carry flag update
    output logic                          carry_we_ff,
    output logic                          carry_ff,
    // General register byte write
    output logic                          reg_we_ff,
    output logic [7:0]                    reg_byte_ff,
    // Memory byte access
    output logic                          mem_rd_ff,
    output logic                          mem_wr_ff,
    output logic [bcu_pkg::ADDR_W-1:0]    mem_addr_ff,
    output logic [7:0]                    mem_wdata_ff,
    input  wire logic                     mem_ack,
    input  wire logic [7:0]               mem_rdata,
    // Program counter load
    output logic                          pc_load_ff,
    output logic [bcu_pkg::ADDR_W-1:0]    pc_ff
);
    typedef enum logic [1:0] {ST_IDLE, ST_MEM_RD, ST_MEM_WR} bcu_state_e;

    logic              rst_meta_ff;
    logic              rst_n_s;
    bcu_state_e        state_ff;
    bcu_state_e        nxt_state;
    logic              accept;
    logic              nxt_ready;
    logic              nxt_done;
    logic              nxt_carry_we;
    logic              nxt_carry;
    logic              nxt_reg_we;
    logic [7:0]        nxt_reg_byte;
    logic              nxt_mem_rd;
    logic              nxt_mem_wr;
    logic [ADDR_W-1:0] nxt_mem_addr;
    logic [7:0]        nxt_mem_wdata;
    logic              nxt_pc_load;
    logic [ADDR_W-1:0] nxt_pc;
    bcu_op_e           sav_op_ff;
    bcu_op_e           nxt_sav_op;
    logic [2:0]        sav_bit_ff;
    logic [2:0]        nxt_sav_bit;
    logic              sav_carry_ff;
    logic              nxt_sav_carry;
    logic [SP_W-1:0]   sp_ff;
    logic [SP_W-1:0]   nxt_sp;
    logic [ADDR_W-1:0] stack_ff [STACK_DEPTH];
    logic [ADDR_W-1:0] nxt_stack [STACK_DEPTH];
    bcu_op_e           bo_op;
    logic [2:0]        bo_bit;
    logic [7:0]        bo_byte;
    logic              bo_carry_in;
    logic              bo_carry;
    logic              bo_carry_we;
    logic [7:0]        bo_byte_out;
    logic              bo_byte_we;
    logic              cond_taken;

    // Reset release is synchronised; assertion is immediate
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_s     <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_s     <= rst_meta_ff;
        end
    end

    assign accept = req_ready_ff & req_valid;

    // In the memory phases the saved operation works on the fetched byte
    always_comb begin
        if (state_ff == ST_IDLE) begin
            bo_op       = req.op;
            bo_bit      = req.bit_idx;
            bo_byte     = req.operand;
            bo_carry_in = flags.c;
        end else begin
            bo_op       = sav_op_ff;
            bo_bit      = sav_bit_ff;
            bo_byte     = mem_rdata;
            bo_carry_in = sav_carry_ff;
        end
    end

    bcu_bitop u_bitop (
        .op        (bo_op),
        .bit_idx   (bo_bit),
        .byte_in   (bo_byte),
        .carry_in  (bo_carry_in),
        .carry_out (bo_carry),
        .carry_we  (bo_carry_we),
        .byte_out  (bo_byte_out),
        .byte_we   (bo_byte_we)
    );

    bcu_cond u_cond (
        .flags (flags),
        .cond  (req.cond),
        .taken (cond_taken)
    );

    always_comb begin
        nxt_state     = state_ff;
        nxt_done      = 1'b0;
        nxt_carry_we  = 1'b0;
        nxt_carry     = carry_ff;
        nxt_reg_we    = 1'b0;
        nxt_reg_byte  = reg_byte_ff;
        nxt_mem_rd    = mem_rd_ff;
        nxt_mem_wr    = mem_wr_ff;
        nxt_mem_addr  = mem_addr_ff;
        nxt_mem_wdata = mem_wdata_ff;
        nxt_pc_load   = 1'b0;
        nxt_pc        = pc_ff;
        nxt_sav_op    = sav_op_ff;
        nxt_sav_bit   = sav_bit_ff;
        nxt_sav_carry = sav_carry_ff;
        nxt_sp        = sp_ff;
        nxt_stack     = stack_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    if (bcu_is_store(req.op) && req.mem_sel) begin
                        nxt_mem_rd    = 1'b1;
                        nxt_mem_addr  = req.addr;
                        nxt_sav_op    = req.op;
                        nxt_sav_bit   = req.bit_idx;
                        nxt_sav_carry = flags.c;
                        nxt_state     = ST_MEM_RD;
                    end else begin
                        nxt_done     = 1'b1;
                        nxt_carry_we = bo_carry_we;
                        nxt_carry    = bo_carry_we ? bo_carry : carry_ff;
                        nxt_reg_we   = bo_byte_we;
                        nxt_reg_byte = bo_byte_we ? bo_byte_out : reg_byte_ff;
                        case (req.op)
                            OP_BRANCH: begin
                                nxt_pc_load = cond_taken;
                                nxt_pc      = cond_taken ? req.target : pc_ff;
                            end
                            OP_UNCONDITIONAL_JUMP: begin
                                nxt_pc_load = 1'b1;
                                nxt_pc      = req.target;
                            end
                            OP_RELATIVE_SUBROUTINE_CALL, OP_SUBROUTINE_CALL: begin
                                nxt_stack[sp_ff] = req.next_pc;
                                nxt_sp           = sp_ff + SP_STEP;
                                nxt_pc_load      = 1'b1;
                                nxt_pc           = req.target;
                            end
                            OP_RETURN: begin
                                nxt_sp      = sp_ff - SP_STEP;
                                nxt_pc_load = 1'b1;
                                nxt_pc      = stack_ff[sp_ff - SP_STEP];
                            end
                            default: nxt_pc_load = 1'b0;
                        endcase
                    end
                end
            end
            ST_MEM_RD: begin
                if (mem_ack) begin
                    nxt_mem_rd    = 1'b0;
                    nxt_mem_wr    = 1'b1;
                    nxt_mem_wdata = bo_byte_out;
                    nxt_state     = ST_MEM_WR;
                end
            end
            ST_MEM_WR: begin
                if (mem_ack) begin
                    nxt_mem_wr = 1'b0;
                    nxt_done   = 1'b1;
                    nxt_state  = ST_IDLE;
                end
            end
        endcase
        nxt_ready = (nxt_state == ST_IDLE);
    end

    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state_ff     <= ST_IDLE;
            req_ready_ff <= 1'b0;
            done_ff      <= 1'b0;
            carry_we_ff  <= 1'b0;
            carry_ff     <= 1'b0;
            reg_we_ff    <= 1'b0;
            reg_byte_ff  <= BYTE_RESET;
            mem_rd_ff    <= 1'b0;
            mem_wr_ff    <= 1'b0;
            mem_addr_ff  <= PC_RESET;
            mem_wdata_ff <= BYTE_RESET;
            pc_load_ff   <= 1'b0;
            pc_ff        <= PC_RESET;
            sav_op_ff    <= OP_CARRY_OR_BIT;
            sav_bit_ff   <= 3'h0;
            sav_carry_ff <= 1'b0;
            sp_ff        <= SP_RESET;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_ff[i] <= PC_RESET;
            end
        end else begin
            state_ff     <= nxt_state;
            req_ready_ff <= nxt_ready;
            done_ff      <= nxt_done;
            carry_we_ff  <= nxt_carry_we;
            carry_ff     <= nxt_carry;
            reg_we_ff    <= nxt_reg_we;
            reg_byte_ff  <= nxt_reg_byte;
            mem_rd_ff    <= nxt_mem_rd;
            mem_wr_ff    <= nxt_mem_wr;
            mem_addr_ff  <= nxt_mem_addr;
            mem_wdata_ff <= nxt_mem_wdata;
            pc_load_ff   <= nxt_pc_load;
            pc_ff        <= nxt_pc;
            sav_op_ff    <= nxt_sav_op;
            sav_bit_ff   <= nxt_sav_bit;
            sav_carry_ff <= nxt_sav_carry;
            sp_ff        <= nxt_sp;
            stack_ff     <= nxt_stack;
        end
    end

    chk_or_carry: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        accept && req.op == OP_CARRY_OR_BIT
        |=> carry_we_ff && carry_ff == ($past(flags.c) | $past(req.operand[req.bit_idx])))
        else $error("carry or-bit result wrong");

    chk_ior_carry: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        accept && req.op == OP_CARRY_OR_INVERTED_BIT
        |=> carry_we_ff && carry_ff == ($past(flags.c) | !$past(req.operand[req.bit_idx])))
        else $error("carry or-inverted result wrong");

    chk_xor_carry: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        accept && req.op == OP_CARRY_XOR_BIT
        |=> carry_ff == ($past(flags.c) ^ $past(req.operand[req.bit_idx])))
        else $error("carry xor-bit result wrong");

    chk_ixor_carry: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        accept && req.op == OP_CARRY_XOR_INVERTED_BIT
        |=> carry_ff != ($past(flags.c) ^ $past(req.operand[req.bit_idx])))
        else $error("carry xor-inverted result wrong");

    chk_load_carry: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        accept && req.op == OP_LOAD_BIT_TO_CARRY
        |=> carry_we_ff && carry_ff == $past(req.operand[req.bit_idx]))
        else $error("load bit to carry wrong");

    chk_iload_carry: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        accept && req.op == OP_LOAD_INVERTED_BIT_TO_CARRY
        |=> carry_ff != $past(req.operand[req.bit_idx]))
        else $error("load inverted bit wrong");

    chk_store_reg: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        accept && req.op == OP_STORE_CARRY_TO_BIT && !req.mem_sel
        |=> reg_we_ff && !carry_we_ff && reg_byte_ff[$past(req.bit_idx)] == $past(flags.c)
            && (reg_byte_ff ^ $past(req.operand)) == (($past(req.operand[req.bit_idx]) ^ $past(flags.c)) << $past(req.bit_idx)))
        else $error("store carry to register byte wrong");

    chk_istore_reg: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        accept && req.op == OP_STORE_INVERTED_CARRY_TO_BIT && !req.mem_sel
        |=> reg_we_ff && reg_byte_ff[$past(req.bit_idx)] == !$past(flags.c))
        else $error("store inverted carry wrong");

    chk_rmw_addr: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        mem_rd_ff && mem_ack |=> mem_wr_ff && !mem_rd_ff && mem_addr_ff == $past(mem_addr_ff))
        else $error("write-back not at read address");

    chk_branch_eq: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        accept && req.op == OP_BRANCH && req.cond == CC_BRANCH_EQUAL
        |=> pc_load_ff == $past(flags.z))
        else $error("equal branch decision wrong");

    chk_branch_gt: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        accept && req.op == OP_BRANCH && req.cond == CC_BRANCH_SIGNED_GREATER
        |=> pc_load_ff == !($past(flags.z) | ($past(flags.n) ^ $past(flags.v))))
        else $error("signed greater branch decision wrong");

    chk_jump_target: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        accept && req.op == OP_UNCONDITIONAL_JUMP |=> pc_load_ff && pc_ff == $past(req.target))
        else $error("jump target not loaded");

    chk_call_return: assert property (
        @(posedge mclk) disable iff (!rst_n_s)
        accept && bcu_is_call(req.op) ##1 !accept ##1 (accept && req.op == OP_RETURN)
        |=> pc_load_ff && pc_ff == $past(req.next_pc, 3))
        else $error("return does not resume after call");
endmodule
`default_nettype wire

// ==== tb/bcu_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module bcu_mem_model (
    // Requests from the unit
    input  wire logic       mclk,
    input  wire logic       rd,
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    input  wire logic [3:0] wait_cyc,
    // Answer and stored byte
    output logic            ack,
    output logic [7:0]      rdata,
    output logic [7:0]      mem_byte
);
    logic [3:0] cnt = 4'h0;
    initial begin
        ack = 1'b0;
        rdata = 8'h00;
        mem_byte = 8'h5a;
    end
    // Read data toggles outside an ack so a late sample cannot match
    always @(posedge mclk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if ((rd || wr) && !ack) begin
            cnt <= cnt + 4'h1;
            if (cnt == wait_cyc) begin
                ack <= 1'b1;
                cnt <= 4'h0;
                if (rd)
                    rdata <= mem_byte;
            end
        end
        if (wr && ack)
            mem_byte <= wdata;
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import bcu_pkg::*;
    typedef struct {bcu_op_e op; logic [2:0] i; logic [7:0] d; logic c; logic [7:0] e;} bcu_row_s;
    logic mclk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
    bcu_req_s req = '0;
    bcu_flags_s flags = '0;
    logic [3:0] wait_cyc = 4'h0;
    logic req_ready_ff, done_ff, carry_we_ff, carry_ff, reg_we_ff, mem_rd_ff, mem_wr_ff, mem_ack, pc_load_ff;
    logic [7:0] reg_byte_ff, mem_wdata_ff, mem_rdata, mem_byte;
    logic [23:0] mem_addr_ff, pc_ff;
    int miscompares = 0, checks_done = 0, cycles = 0, n;
    bcu_row_s rows [8] = '{'{OP_CARRY_OR_BIT, 3'h3, 8'h08, 1'b0, 8'h01},
        '{OP_CARRY_OR_INVERTED_BIT, 3'h3, 8'h08, 1'b0, 8'h00}, '{OP_CARRY_XOR_BIT, 3'h7, 8'h80, 1'b1, 8'h00},
        '{OP_CARRY_XOR_INVERTED_BIT, 3'h7, 8'h80, 1'b1, 8'h01}, '{OP_LOAD_BIT_TO_CARRY, 3'h0, 8'hfe, 1'b1, 8'h00},
        '{OP_LOAD_INVERTED_BIT_TO_CARRY, 3'h0, 8'hfe, 1'b0, 8'h01},
        '{OP_STORE_CARRY_TO_BIT, 3'h5, 8'h00, 1'b1, 8'h20}, '{OP_STORE_INVERTED_CARRY_TO_BIT, 3'h5, 8'hff, 1'b1, 8'hdf}};

    bcu_core bcu_core_inst (.mclk, .rst_n, .req_valid, .req, .flags, .req_ready_ff, .done_ff, .carry_we_ff,
        .carry_ff, .reg_we_ff, .reg_byte_ff, .mem_rd_ff, .mem_wr_ff, .mem_addr_ff, .mem_wdata_ff, .mem_ack,
        .mem_rdata, .pc_load_ff, .pc_ff);
    bcu_mem_model bcu_mem_model_inst (.mclk, .rd(mem_rd_ff), .wr(mem_wr_ff), .wdata(mem_wdata_ff), .wait_cyc,
        .ack(mem_ack), .rdata(mem_rdata), .mem_byte);

    always #10 mclk = ~mclk;

    task automatic check(string name, logic [23:0] exp, logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One request held for one edge; outputs are looked at in the cycle after
    task automatic issue(bcu_op_e op, logic [2:0] i, logic [7:0] d, logic [3:0] f, logic [3:0] cc,
                         logic [23:0] tgt, logic m);
        @(negedge mclk);
        req = '{op, i, m, d, tgt, cc, tgt, tgt + 24'h2};
        flags = f;
        req_valid = 1'b1;
        @(negedge mclk);
        req_valid = 1'b0;
        if (!m) check("done", 1, done_ff);
    endtask

    function automatic logic cond_true(logic [3:0] cc, bcu_flags_s g);
        logic [15:0] t;
        t = {g.z | (g.n ^ g.v), ~(g.z | (g.n ^ g.v)), g.n ^ g.v, ~(g.n ^ g.v), g.n, ~g.n, g.v, ~g.v,
             g.z, ~g.z, g.c, ~g.c, g.c | g.z, ~(g.c | g.z), 1'b0, 1'b1};
        return t[cc];
    endfunction

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        repeat (10) @(negedge mclk);
        check("ready_rst", 0, req_ready_ff);
        check("pc_rst", 0, pc_ff);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        check("ready", 1, req_ready_ff);
        foreach (rows[k]) begin
            issue(rows[k].op, rows[k].i, rows[k].d, {3'h0, rows[k].c}, 4'h0, 24'h0, 1'b0);
            check("carry_we", k < 6, carry_we_ff);
            check("reg_we", k >= 6, reg_we_ff);
            if (k < 6) check("carry", rows[k].e[0], carry_ff);
            else check("byte", rows[k].e, reg_byte_ff);
        end
        for (int cc = 0; cc < 16; cc++)
            for (int f = 0; f < 16; f++) begin
                issue(OP_BRANCH, 3'h0, 8'h00, f[3:0], cc[3:0], 24'h000100 + 24'(f), 1'b0);
                check("pc_load", cond_true(cc[3:0], f[3:0]), pc_load_ff);
                if (pc_load_ff === 1'b1) check("pc", 24'h000100 + 24'(f), pc_ff);
            end
        issue(OP_UNCONDITIONAL_JUMP, 3'h0, 8'h00, 4'hf, 4'h1, 24'habcdef, 1'b0);
        check("jump", 24'habcdef, pc_load_ff ? pc_ff : 24'h0);
        issue(OP_SUBROUTINE_CALL, 3'h0, 8'h00, 4'h0, 4'h0, 24'h001000, 1'b0);
        check("call", 24'h001000, pc_ff);
        issue(OP_RELATIVE_SUBROUTINE_CALL, 3'h0, 8'h00, 4'h0, 4'h0, 24'h002000, 1'b0);
        check("call_rel", 24'h002000, pc_ff);
        issue(OP_RETURN, 3'h0, 8'h00, 4'h0, 4'h0, 24'h0, 1'b0);
        check("ret_inner", 24'h002002, pc_ff);
        issue(OP_RETURN, 3'h0, 8'h00, 4'h0, 4'h0, 24'h0, 1'b0);
        check("ret_outer", 24'h001002, pc_load_ff ? pc_ff : 24'h0);
        // Operand is left zero: a memory store must use the byte read back
        for (int s = 0; s < 2; s++) begin
            wait_cyc = s ? 4'h3 : 4'h0;
            issue(s ? OP_STORE_INVERTED_CARRY_TO_BIT : OP_STORE_CARRY_TO_BIT, s ? 3'h6 : 3'h0, 8'h00, 4'h1, 4'h0,
                  24'h123456, 1'b1);
            check("mem_rd", 1, mem_rd_ff);
            check("mem_addr", 24'h123456, mem_addr_ff);
            n = 0;
            while (done_ff !== 1'b1 && n < 40) begin
                @(negedge mclk);
                n++;
            end
            check("mem_done", 1, done_ff);
            check("mem_byte", s ? 8'h1b : 8'h5b, mem_byte);
        end
        rst_n = 1'b0;
        #1 check("pc_async", 0, pc_ff);
        @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        issue(OP_RETURN, 3'h0, 8'h00, 4'h0, 4'h0, 24'h0, 1'b0);
        check("ret_empty", 0, pc_ff);
        check("ret_load", 1, pc_load_ff);
        test_done();
    end
endmodule
`default_nettype wire
